// File: chgopt_pkg.sv
// constants and types for the charge option upper control block
package chgopt_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CHARGE_OPTION_LOWER_OFS = 8'h00;
  localparam logic [7:0] CHARGE_OPTION_UPPER_OFS = 8'h01;
  localparam logic [7:0] CHARGE_CURRENT_LO_OFS   = 8'h02;
  localparam logic [7:0] CHARGE_CURRENT_HI_OFS   = 8'h03;
  localparam logic [7:0] CHARGE_VOLTAGE_LO_OFS   = 8'h04;
  localparam logic [7:0] CHARGE_VOLTAGE_HI_OFS   = 8'h05;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         INPUT_LIMIT_LOOP_BIT    = 1;
  localparam int         SWITCHING_RATE_BIT      = 1;
  localparam logic [7:0] CHARGE_OPTION_UPPER_RST = 8'hE7;
  localparam logic       INPUT_LIMIT_LOOP_RST    = 1'h1;

  localparam logic [1:0] TIMEOUT_OFF   = 2'h0;
  localparam logic [1:0] TIMEOUT_SHORT = 2'h1;
  localparam logic [1:0] TIMEOUT_MID   = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          SECOND_NS       = 1_000_000_000;
  localparam int          SECOND_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [7:0]  TIMEOUT_SHORT_S = 8'h05;
  localparam logic [7:0]  TIMEOUT_MID_S   = 8'h58;
  localparam logic [7:0]  TIMEOUT_LONG_S  = 8'hAF;

  // ----------------------------------------------------------------
  // register layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       quiescentSaverEnable;
    logic [1:0] chargeTimeoutSelect;
    logic       inputLimitAutoOff;
    logic       reverseModeFlagsGood;
    logic       audioBandAvoid;
    logic       switchingRateSelect;
    logic       batteryOvervoltEnable;
  } chgopt_upper_t;

  typedef enum logic [1:0] {TmrIdle, TmrRun, TmrExpired} chgopt_tmr_t;

endpackage : chgopt_pkg

// File: chgopt_upper_control.sv
// charge option upper byte: low-power gating, charge timeout, input limit and rate control
`timescale 1ns/1ps
`default_nettype none

module chgopt_upper_control
  import chgopt_pkg::*;
#(
  parameter int SECOND_TICK_CYCLES = SECOND_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       softReset,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       timeoutRestart,
  input  wire logic       chargeSettingsValid,
  input  wire logic       batteryPresentPin,
  input  wire logic       batteryOnly,
  input  wire logic       reverseModeActive,
  input  wire logic       adapterOk,
  input  wire logic       converterHiz,
  input  wire logic       modePinDone,
  input  wire logic       modePinRate,
  input  wire logic       saverComparatorEnable,
  input  wire logic       saverRegulatorEnable,
  input  wire logic       hotAlertSetting,
  input  wire logic       monitorSetting,
  input  wire logic       comparatorSetting,
  output logic            processorHotAlertEnable,
  output logic            monitorBuffersEnable,
  output logic            comparatorEnable,
  output logic            adcAvailable,
  output logic            internalRegulatorOn,
  output logic            regulatorReducedCurrent,
  output logic            adapterGoodOutput,
  output logic            audioBandAvoidOut,
  output logic            switchingRate600,
  output logic            batteryOvervoltEnableOut,
  output logic            inputLimitRegEnable,
  output logic            reverseCurrentRegEnable,
  output logic            chargeSuspend,
  output logic            chargeEnable
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // timeout decode
  function automatic logic [7:0] timeoutSeconds(input logic [1:0] sel);
    unique case (sel)
      TIMEOUT_OFF:   timeoutSeconds = 8'h00;
      TIMEOUT_SHORT: timeoutSeconds = TIMEOUT_SHORT_S;
      TIMEOUT_MID:   timeoutSeconds = TIMEOUT_MID_S;
      default:       timeoutSeconds = TIMEOUT_LONG_S;
    endcase
  endfunction : timeoutSeconds

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  chgopt_upper_t upper_reg, upper_next;
  logic          inputLimit_reg, inputLimit_next;
  logic          rateApplied_reg, rateApplied_next;
  logic          modeLoaded_reg, modeLoaded_next;
  logic [7:0]    rdData_reg, rdData_next;
  logic          wrUpper, wrLower, wrCharge;

  assign wrUpper  = regWrite && (regAddr == CHARGE_OPTION_UPPER_OFS);
  assign wrLower  = regWrite && (regAddr == CHARGE_OPTION_LOWER_OFS);
  assign wrCharge = regWrite && ((regAddr == CHARGE_CURRENT_LO_OFS) ||
                                 (regAddr == CHARGE_CURRENT_HI_OFS) ||
                                 (regAddr == CHARGE_VOLTAGE_LO_OFS) ||
                                 (regAddr == CHARGE_VOLTAGE_HI_OFS));

  always_comb begin
    upper_next       = upper_reg;
    inputLimit_next  = inputLimit_reg;
    rateApplied_next = rateApplied_reg;
    modeLoaded_next  = modeLoaded_reg;
    rdData_next      = rdData_reg;
    if (wrUpper) begin
      upper_next = chgopt_upper_t'(regWdata);
    end
    if (wrLower) begin
      inputLimit_next = regWdata[INPUT_LIMIT_LOOP_BIT];
    end
    if (modePinDone && !modeLoaded_reg) begin
      upper_next.switchingRateSelect = modePinRate;
      modeLoaded_next                = 1'b1;
    end
    if (softReset) begin
      upper_next                     = chgopt_upper_t'(CHARGE_OPTION_UPPER_RST);
      upper_next.switchingRateSelect = upper_reg.switchingRateSelect;
      inputLimit_next                = INPUT_LIMIT_LOOP_RST;
    end
    // auto-off; a persisting low pin wins over a host write
    if (upper_reg.inputLimitAutoOff && !batteryPresentPin) begin
      inputLimit_next = 1'b0;
    end
    if (converterHiz) begin
      rateApplied_next = upper_reg.switchingRateSelect;
    end
    if (regRead) begin
      unique case (regAddr)
        CHARGE_OPTION_UPPER_OFS: rdData_next = 8'(upper_reg);
        CHARGE_OPTION_LOWER_OFS: rdData_next = 8'(inputLimit_reg) << INPUT_LIMIT_LOOP_BIT;
        default:                 rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      upper_reg       <= chgopt_upper_t'(CHARGE_OPTION_UPPER_RST);
      inputLimit_reg  <= INPUT_LIMIT_LOOP_RST;
      rateApplied_reg <= CHARGE_OPTION_UPPER_RST[SWITCHING_RATE_BIT];
      modeLoaded_reg  <= 1'b0;
      rdData_reg      <= 8'h00;
    end else begin
      upper_reg       <= upper_next;
      inputLimit_reg  <= inputLimit_next;
      rateApplied_reg <= rateApplied_next;
      modeLoaded_reg  <= modeLoaded_next;
      rdData_reg      <= rdData_next;
    end
  end

  // ----------------------------------------------------------------
  // charge timeout
  // ----------------------------------------------------------------
  // one-second enable pulse keeps the counter narrow
  chgopt_tmr_t tmrState_reg, tmrState_next;
  logic [31:0] tickCnt_reg, tickCnt_next;
  logic [7:0]  secCnt_reg, secCnt_next;
  logic        qualWrite, secTick;

  assign qualWrite = wrCharge || wrUpper || timeoutRestart;
  assign secTick   = (tickCnt_reg == 32'(SECOND_TICK_CYCLES - 1));

  always_comb begin
    tmrState_next = tmrState_reg;
    tickCnt_next  = secTick ? 32'h0 : tickCnt_reg + 32'h1;
    secCnt_next   = secCnt_reg;
    unique case (tmrState_reg)
      TmrIdle: begin
        if (upper_reg.chargeTimeoutSelect != TIMEOUT_OFF) begin
          tmrState_next = TmrRun;
        end
      end
      TmrRun: begin
        if (upper_reg.chargeTimeoutSelect == TIMEOUT_OFF) begin
          tmrState_next = TmrIdle;
        end else if (secTick && (secCnt_reg + 8'h1 >= timeoutSeconds(upper_reg.chargeTimeoutSelect))) begin
          tmrState_next = TmrExpired;
        end else if (secTick) begin
          secCnt_next = secCnt_reg + 8'h1;
        end
      end
      TmrExpired: begin
      end
    endcase
    if (qualWrite || softReset) begin
      tmrState_next = TmrIdle;
      tickCnt_next  = 32'h0;
      secCnt_next   = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tmrState_reg <= TmrIdle;
      tickCnt_reg  <= 32'h0;
      secCnt_reg   <= 8'h00;
    end else begin
      tmrState_reg <= tmrState_next;
      tickCnt_reg  <= tickCnt_next;
      secCnt_reg   <= secCnt_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic saver;
  assign saver = upper_reg.quiescentSaverEnable && batteryOnly;

  assign processorHotAlertEnable = !saver && hotAlertSetting;
  assign monitorBuffersEnable    = !saver && monitorSetting;
  assign adcAvailable            = !saver;
  // comparator kept by its saver enable
  assign comparatorEnable        = saver ? saverComparatorEnable : comparatorSetting;
  assign internalRegulatorOn     = !saver || saverRegulatorEnable;
  assign regulatorReducedCurrent = saver && saverRegulatorEnable;
  assign adapterGoodOutput       = adapterOk ||
                                   (upper_reg.reverseModeFlagsGood && reverseModeActive);
  assign audioBandAvoidOut       = upper_reg.audioBandAvoid;
  assign switchingRate600        = rateApplied_reg;
  assign batteryOvervoltEnableOut = upper_reg.batteryOvervoltEnable;
  assign inputLimitRegEnable     = inputLimit_reg && !reverseModeActive;
  assign reverseCurrentRegEnable = inputLimit_reg && reverseModeActive;
  assign chargeSuspend           = (tmrState_reg == TmrExpired);
  assign chargeEnable            = !chargeSuspend && chargeSettingsValid;
  assign regRdata                = rdData_reg;

endmodule : chgopt_upper_control

`default_nettype wire

// File: chgopt_checker.sv
// port checker for the charge option upper control block
`timescale 1ns/1ps
`default_nettype none
module chgopt_checker
  import chgopt_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       softReset,
  input wire logic [7:0] regAddr,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       timeoutRestart,
  input wire logic       chargeSettingsValid,
  input wire logic       reverseModeActive,
  input wire logic       adapterOk,
  input wire logic       converterHiz,
  input wire logic       modePinDone,
  input wire logic       adapterGoodOutput,
  input wire logic       audioBandAvoidOut,
  input wire logic       switchingRate600,
  input wire logic       reverseCurrentRegEnable,
  input wire logic       chargeSuspend,
  input wire logic       chargeEnable
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // any host event that reloads the charge timeout
  logic qual;
  assign qual = timeoutRestart || (regWrite && regAddr >= 8'h01 && regAddr <= 8'h05);
  charge_gate_a: assert property (
    chargeEnable == (!chargeSuspend && chargeSettingsValid)) else $error("charge gate wrong");
  suspend_hold_a: assert property (
    chargeSuspend && !qual && !softReset |=> chargeSuspend) else $error("suspend dropped");
  restart_clear_a: assert property (
    qual && !softReset |=> !chargeSuspend) else $error("suspend not cleared");
  rate_hold_a: assert property (
    !converterHiz && !modePinDone |=> $stable(switchingRate600)) else $error("rate moved");
  audio_bit_a: assert property (
    regWrite && regAddr == 8'h01 && !softReset |=> audioBandAvoidOut == $past(regWdata[2]))
    else $error("audio bit wrong");
  upper_readback_a: assert property (
    regWrite && regAddr == 8'h01 && !softReset ##1 !softReset ##1 regRead && !regWrite
    && regAddr == 8'h01 && !softReset |=> regRdata == $past(regWdata, 3))
    else $error("readback wrong");
  unmapped_read_a: assert property (
    regRead && regAddr > 8'h05 |=> regRdata == 8'h00) else $error("unmapped read wrong");
  adapter_base_a: assert property (
    !reverseModeActive |-> adapterGoodOutput == adapterOk) else $error("adapter good wrong");
  reverse_gate_a: assert property (
    !reverseModeActive |-> !reverseCurrentRegEnable) else $error("reverse limit on");
endmodule : chgopt_checker
bind chgopt_upper_control chgopt_checker u_chk (.core_clk, .reset, .softReset, .regAddr,
  .regWrite, .regRead, .regWdata, .regRdata, .timeoutRestart, .chargeSettingsValid,
  .reverseModeActive, .adapterOk, .converterHiz, .modePinDone, .adapterGoodOutput,
  .audioBandAvoidOut, .switchingRate600, .reverseCurrentRegEnable, .chargeSuspend,
  .chargeEnable);
`default_nettype wire

// File: chgopt_host_model.sv
// host model driving the byte register port
`timescale 1ns/1ps
`default_nettype none
module chgopt_host_model
  import chgopt_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic [7:0] regRdata,
  output var  logic [7:0] regAddr,
  output var  logic       regWrite,
  output var  logic       regRead,
  output var  logic [7:0] regWdata,
  output var  logic       timeoutRestart
);
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  initial begin
    {regAddr, regWdata} = 16'h0000;
    {regWrite, regRead, timeoutRestart} = 3'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    // inverted on release so stale data never passes
    regWdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic kick();
    @(posedge core_clk);
    timeoutRestart <= 1'b1;
    @(posedge core_clk);
    timeoutRestart <= 1'b0;
  endtask : kick
endmodule : chgopt_host_model
`default_nettype wire

// File: chgopt_upper_control_tb_top.sv
// self-checking bench for the charge option upper control block
`timescale 1ns/1ps
`default_nettype none
module chgopt_upper_control_tb_top
  import chgopt_pkg::*;
;
  // ----------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------
  // short second keeps the timeout run small
  localparam int TICK = 4;
  logic       core_clk, reset, softReset, regWrite, regRead, timeoutRestart;
  logic [7:0] regAddr, regWdata, regRdata, d;
  logic       valid, batOnly, batPin, revMode, hiz, own, svCmp, svReg, adOk, pinDone, pinRate;
  wire  [5:0] lp;
  wire  [7:0] st;
  int         n, miscompares, checks;
  chgopt_host_model u_host (.core_clk, .regRdata, .regAddr, .regWrite, .regRead, .regWdata,
    .timeoutRestart);
  chgopt_upper_control #(.SECOND_TICK_CYCLES(TICK)) u_dut (.core_clk, .reset, .softReset,
    .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .timeoutRestart,
    .chargeSettingsValid(valid), .batteryPresentPin(batPin), .batteryOnly(batOnly),
    .reverseModeActive(revMode), .adapterOk(adOk), .converterHiz(hiz), .modePinDone(pinDone),
    .modePinRate(pinRate), .saverComparatorEnable(svCmp), .saverRegulatorEnable(svReg),
    .hotAlertSetting(own), .monitorSetting(own), .comparatorSetting(own),
    .processorHotAlertEnable(lp[5]), .monitorBuffersEnable(lp[4]), .comparatorEnable(lp[3]),
    .adcAvailable(lp[2]), .internalRegulatorOn(lp[1]), .regulatorReducedCurrent(lp[0]),
    .chargeSuspend(st[7]), .chargeEnable(st[6]), .adapterGoodOutput(st[5]),
    .audioBandAvoidOut(st[4]), .switchingRate600(st[3]), .batteryOvervoltEnableOut(st[2]),
    .inputLimitRegEnable(st[1]), .reverseCurrentRegEnable(st[0]));
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    {softReset, valid, revMode, hiz, own, svCmp, adOk, pinDone, pinRate} = 9'h000;
    {reset, batOnly, batPin, svReg} = 4'hF;
    {miscompares, checks} = 0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    u_host.rd(8'h01, d);
    chk("upper", d, CHARGE_OPTION_UPPER_RST);
    u_host.rd(8'h00, d);
    chk("lower", d, 8'h02);
    u_host.rd(8'h09, d);
    chk("unmapped", d, 8'h00);
    chk("saver", {2'h0, lp}, 8'h03);
    chk("status", st & 8'h3F, 8'h1E);
    // rate on the second cycle of the pin pulse must be ignored
    @(posedge core_clk);
    {pinDone, pinRate} <= 2'h2;
    @(posedge core_clk);
    {pinDone, pinRate} <= 2'h3;
    @(posedge core_clk);
    pinDone <= 1'b0;
    u_host.rd(8'h01, d);
    chk("mode pin", d, 8'hE5);
    @(posedge core_clk);
    {svCmp, own, svReg} <= 3'h2;
    #1 chk("saver gate", {2'h0, lp}, 8'h00);
    @(posedge core_clk);
    {svCmp, own, svReg} <= 3'h6;
    #1 chk("saver cmp", {2'h0, lp}, 8'h08);
    u_host.wr(8'h01, 8'h67);
    #1 chk("perf", {2'h0, lp}, 8'h3E);
    u_host.rd(8'h01, d);
    chk("upper back", d, 8'h67);
    u_host.wr(8'h01, 8'h65);
    #1 chk("rate held", st & 8'h3F, 8'h1E);
    @(posedge core_clk);
    hiz <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk("rate hiz", st & 8'h3F, 8'h16);
    hiz <= 1'b0;
    u_host.wr(8'h01, 8'h75);
    batPin <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk("auto off", st & 8'h3F, 8'h14);
    u_host.rd(8'h00, d);
    chk("loop bit", d, 8'h00);
    batPin <= 1'b1;
    u_host.wr(8'h00, 8'h02);
    u_host.rd(8'h00, d);
    chk("loop back", d, 8'h02);
    u_host.wr(8'h01, 8'h7D);
    revMode <= 1'b1;
    @(posedge core_clk);
    #1 chk("reverse", st & 8'h3D, 8'h35);
    u_host.wr(8'h01, 8'h00);
    revMode <= 1'b0;
    #1 chk("cleared", st & 8'h3F, 8'h02);
    adOk <= 1'b1;
    @(posedge core_clk);
    #1 chk("adapter ok", st & 8'h3F, 8'h22);
    adOk <= 1'b0;
    @(posedge core_clk);
    softReset <= 1'b1;
    @(posedge core_clk);
    softReset <= 1'b0;
    u_host.rd(8'h01, d);
    chk("soft reset", d, 8'hE5);
    valid <= 1'b1;
    u_host.wr(8'h01, 8'h3D);
    n = 0;
    while (!st[7] && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n == 40) begin
      miscompares++;
    end else begin
      chk("expiry", {7'h0, n >= 19 && n <= 22}, 8'h01);
      chk("suspend", {6'h0, st[7:6]}, 8'h02);
      u_host.kick();
      @(posedge core_clk);
      #1 chk("restart", {6'h0, st[7:6]}, 8'h01);
      repeat (15) @(posedge core_clk);
      u_host.wr(8'h02, 8'h00);
      repeat (15) @(posedge core_clk);
      #1 chk("reload", {6'h0, st[7:6]}, 8'h01);
      u_host.wr(8'h01, 8'h1D);
      repeat (40) @(posedge core_clk);
      #1 chk("disabled", {6'h0, st[7:6]}, 8'h01);
      valid <= 1'b0;
      @(posedge core_clk);
      #1 chk("invalid", {6'h0, st[7:6]}, 8'h00);
    end
    summarize();
  end
endmodule : chgopt_upper_control_tb_top
`default_nettype wire
